// ### rtl/sdi_interrupt_logic.sv
// Converter and transmitter interrupt logic: mask, mode, status and interrupt pin
`timescale 1ns/1ps
`include "sdi_params.svh"

// Function
// - Rate direction flag sets when input rate higher
// - Rate event drives interrupt low, sets summary
// - Mask bits 5,4,1,0; others read zero
// - Mask zero blocks source; zero after reset
// - Transfer mode bits 1:0 rise/fall/level/reserved
// - Slip mode bits 3:2, same encoding
// - Transfer flag sets on done when enabled, unmasked
// - Rate mode 7:6, ready mode 5:4
module sdi_interrupt_logic
	import sdi_pkg::*;
(
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          srst,
	// Register port
	input  wire sdi_reg_req_t  reg_req,
	input  wire logic          reg_valid,
	output logic [7:0]         reg_rdata,
	// Event conditions from converter and transmitter
	input  wire logic          rate_in_faster,
	input  wire logic          estimator_ready,
	input  wire logic          source_slip,
	input  wire logic          tx_transfer_done,
	input  wire logic          tx_buffer_copy_disable,
	// Status and interrupt
	output logic [7:0]         status_flags,
	output logic               converter_summary_flag,
	output logic               int_n
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] interrupt_enable_mask;
	logic [7:0] interrupt_trigger_mode;
	logic       rate_direction_flag;
	logic       estimator_done_flag;
	logic       source_slip_flag;
	logic       tx_transfer_done_flag;

	wire logic wr_mask  = reg_valid & reg_req.write & (reg_req.addr == `SDI_ADDR_MASK);
	wire logic wr_mode  = reg_valid & reg_req.write & (reg_req.addr == `SDI_ADDR_MODE);
	wire logic rd_stat  = reg_valid & ~reg_req.write & (reg_req.addr == `SDI_ADDR_STATUS);

	wire logic rate_direction_enable   = interrupt_enable_mask[`SDI_BIT_RATE];
	wire logic estimator_done_enable   = interrupt_enable_mask[`SDI_BIT_READY];
	wire logic source_slip_enable      = interrupt_enable_mask[`SDI_BIT_SLIP];
	wire logic tx_transfer_done_enable = interrupt_enable_mask[`SDI_BIT_XFER];

	wire sdi_trig_t rate_direction_trigger =
		sdi_trig_t'(interrupt_trigger_mode[`SDI_MODE_RATE_LSB +: 2]);
	wire sdi_trig_t estimator_done_trigger =
		sdi_trig_t'(interrupt_trigger_mode[`SDI_MODE_READY_LSB +: 2]);
	wire sdi_trig_t source_slip_trigger =
		sdi_trig_t'(interrupt_trigger_mode[`SDI_MODE_SLIP_LSB +: 2]);
	wire sdi_trig_t tx_transfer_done_trigger =
		sdi_trig_t'(interrupt_trigger_mode[`SDI_MODE_XFER_LSB +: 2]);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	sdi_events_t meta;
	sdi_events_t sync;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			meta <= '0;
			sync <= '0;
		end
		else
		begin
			meta <= '{rate_in_faster, estimator_ready, source_slip, tx_transfer_done};
			sync <= meta;
		end
	end

	// ----------------------------------------
	// Trigger detection
	// ----------------------------------------
	sdi_events_t hit;

	sdi_trigger u_trig_rate
	(
		.clock     (clock),
		.srst      (srst),
		.cond      (sync.rate_direction),
		.mode      (rate_direction_trigger),
		.event_hit (hit.rate_direction)
	);

	sdi_trigger u_trig_ready
	(
		.clock     (clock),
		.srst      (srst),
		.cond      (sync.estimator_done),
		.mode      (estimator_done_trigger),
		.event_hit (hit.estimator_done)
	);

	sdi_trigger u_trig_slip
	(
		.clock     (clock),
		.srst      (srst),
		.cond      (sync.source_slip),
		.mode      (source_slip_trigger),
		.event_hit (hit.source_slip)
	);

	sdi_trigger u_trig_xfer
	(
		.clock     (clock),
		.srst      (srst),
		.cond      (sync.tx_transfer_done),
		.mode      (tx_transfer_done_trigger),
		.event_hit (hit.tx_transfer_done)
	);

	// Masked sources never touch their flags
	wire logic set_rate  = hit.rate_direction & rate_direction_enable;
	wire logic set_ready = hit.estimator_done & estimator_done_enable;
	wire logic set_slip  = hit.source_slip & source_slip_enable;
	wire logic set_xfer  = hit.tx_transfer_done & tx_transfer_done_enable
		& ~tx_buffer_copy_disable;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			interrupt_enable_mask  <= `SDI_MASK_RESET;
			interrupt_trigger_mode <= `SDI_MODE_RESET;
		end
		else
		begin
			if (wr_mask)
				interrupt_enable_mask <= reg_req.wdata & `SDI_MASK_USED;
			if (wr_mode)
				interrupt_trigger_mode <= reg_req.wdata;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Flags clear on a status read; an event in that same cycle wins
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rate_direction_flag   <= 1'b0;
			estimator_done_flag   <= 1'b0;
			source_slip_flag      <= 1'b0;
			tx_transfer_done_flag <= 1'b0;
		end
		else
		begin
			rate_direction_flag   <= set_rate  | (rate_direction_flag & ~rd_stat);
			estimator_done_flag   <= set_ready | (estimator_done_flag & ~rd_stat);
			source_slip_flag      <= set_slip  | (source_slip_flag & ~rd_stat);
			tx_transfer_done_flag <= set_xfer  | (tx_transfer_done_flag & ~rd_stat);
		end
	end

	wire logic [7:0] next_status = {2'b00, rate_direction_flag, estimator_done_flag,
		2'b00, source_slip_flag, tx_transfer_done_flag};

	wire logic any_flag = |next_status;

	// ----------------------------------------
	// Read data and outputs
	// ----------------------------------------
	wire logic [7:0] next_rdata =
		(reg_req.addr == `SDI_ADDR_MASK)   ? interrupt_enable_mask :
		(reg_req.addr == `SDI_ADDR_MODE)   ? interrupt_trigger_mode :
		(reg_req.addr == `SDI_ADDR_STATUS) ? next_status :
		(reg_req.addr == `SDI_ADDR_GLOBAL) ? {6'b00_0000, any_flag, 1'b0} :
		8'h00;

	always_ff @(posedge clock)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_valid & ~reg_req.write)
			reg_rdata <= next_rdata;
	end

	assign status_flags           = next_status;
	assign converter_summary_flag = any_flag;
	assign int_n                  = ~any_flag;

endmodule

// ### rtl/sdi_params.svh
// Register offsets, field positions and reset values of the interrupt logic
`ifndef SDI_PARAMS_SVH
`define SDI_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define SDI_ADDR_MASK        8'h0B
`define SDI_ADDR_MODE        8'h0C
`define SDI_ADDR_STATUS      8'h0A
`define SDI_ADDR_GLOBAL      8'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SDI_BIT_RATE         5
`define SDI_BIT_READY        4
`define SDI_BIT_SLIP         1
`define SDI_BIT_XFER         0
`define SDI_MODE_RATE_LSB    6
`define SDI_MODE_READY_LSB   4
`define SDI_MODE_SLIP_LSB    2
`define SDI_MODE_XFER_LSB    0
`define SDI_BIT_SUMMARY      1

// ----------------------------------------
// Reset values and used mask bits
// ----------------------------------------
`define SDI_MASK_RESET       8'h00
`define SDI_MODE_RESET       8'h00
`define SDI_MASK_USED        8'h33

`endif

// ### rtl/sdi_pkg.sv
// Types shared by the interrupt logic
package sdi_pkg;

	typedef enum logic [1:0]
	{
		SDI_TRIG_RISE  = 2'b00,
		SDI_TRIG_FALL  = 2'b01,
		SDI_TRIG_LEVEL = 2'b10,
		SDI_TRIG_RSVD  = 2'b11
	} sdi_trig_t;

	typedef struct packed
	{
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sdi_reg_req_t;

	typedef struct packed
	{
		logic rate_direction;
		logic estimator_done;
		logic source_slip;
		logic tx_transfer_done;
	} sdi_events_t;

endpackage

// ### rtl/sdi_trigger.sv
// One event source: trigger detection per selected mode
`timescale 1ns/1ps
module sdi_trigger
	import sdi_pkg::*;
(
	// Clock and reset
	input  wire logic      clock,
	input  wire logic      srst,
	// Condition and mode
	input  wire logic      cond,
	input  wire sdi_trig_t mode,
	// Event
	output logic           event_hit
);

	logic cond_d;

	always_ff @(posedge clock)
	begin
		if (srst)
			cond_d <= 1'b0;
		else
			cond_d <= cond;
	end

	wire logic rise_hit = cond & ~cond_d;
	wire logic fall_hit = ~cond & cond_d;

	// Reserved code raises nothing so a bad write cannot storm the host
	always_comb
	begin
		unique case (mode)
			SDI_TRIG_RISE:  event_hit = rise_hit;
			SDI_TRIG_FALL:  event_hit = fall_hit;
			SDI_TRIG_LEVEL: event_hit = cond;
			SDI_TRIG_RSVD:  event_hit = 1'b0;
		endcase
	end

endmodule

// ### test/sdi_chk.sv
// Port checker of the interrupt logic
`timescale 1ns/1ps
module sdi_chk
	import sdi_pkg::*;
(
	// Clock, reset, register port
	input wire logic         clock,
	input wire logic         srst,
	input wire sdi_reg_req_t reg_req,
	input wire logic         reg_valid,
	input wire logic [7:0]   reg_rdata,
	// Events and outputs
	input wire logic         rate_in_faster,
	input wire logic         tx_buffer_copy_disable,
	input wire logic [7:0]   status_flags,
	input wire logic         converter_summary_flag,
	input wire logic         int_n
);
	logic [7:0] m;
	logic [7:0] md;
	wire        wr = reg_valid && reg_req.write;
	// Shadows follow the writes, so mask and mode need no internal probe
	always_ff @(posedge clock)
		m <= srst ? 8'h00 : (wr && reg_req.addr == 8'h0B) ? reg_req.wdata & 8'h33 : m;
	always_ff @(posedge clock)
		md <= srst ? 8'h00 : (wr && reg_req.addr == 8'h0C) ? reg_req.wdata : md;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_rise;
		$rose(rate_in_faster) && m[5] && md[7:6] == 2'b00;
	endsequence
	sequence s_lvl;
		(rate_in_faster && m[5] && md[7:6] == 2'b10) [*4];
	endsequence
	a_rate_edge: assert property (s_rise |-> ##3 status_flags[5])
		else $error("rate flag late");
	a_level_hold: assert property (s_lvl |-> status_flags[5])
		else $error("level flag lost");
	a_int_pin: assert property (int_n == !converter_summary_flag)
		else $error("pin mismatch");
	a_summary_or: assert property (converter_summary_flag == |status_flags)
		else $error("summary mismatch");
	a_unused_zero: assert property ((status_flags & 8'hCC) == 8'h00)
		else $error("unused flag set");
	a_mask_block: assert property ($rose(status_flags[4]) |-> $past(m[4]))
		else $error("masked flag set");
	a_copy_block: assert property
		(tx_buffer_copy_disable [*5] |-> !$rose(status_flags[0]))
		else $error("transfer flag while disabled");
	a_read_data: assert property
		(reg_valid && !reg_req.write && reg_req.addr == 8'h0A |=> reg_rdata == $past(status_flags))
		else $error("status read wrong");
endmodule
bind sdi_interrupt_logic sdi_chk sdi_chk_inst (.*);

// ### test/sdi_host.sv
// Host model counting interrupt requests
`timescale 1ns/1ps
module sdi_host
(
	// Clock and pin
	input  wire logic clock,
	input  wire logic int_n,
	// Requests seen
	output logic [7:0] irq_cnt
);
	logic int_n_d = 1'b1;
	initial irq_cnt = 8'h00;
	// Sampled on the clock so a glitch between edges is not counted
	always @(posedge clock)
	begin
		int_n_d <= int_n;
		if (int_n_d && !int_n)
			irq_cnt <= irq_cnt + 8'h01;
	end
endmodule

// ### test/tb.sv
// Self-checking testbench of the interrupt logic
`timescale 1ns/1ps
module tb;
	import sdi_pkg::*;
	logic         clock;
	logic         srst = 1'b1;
	sdi_reg_req_t reg_req = '0;
	logic         reg_valid = 1'b0;
	logic [7:0]   reg_rdata;
	logic         rate_in_faster = 1'b0;
	logic         estimator_ready = 1'b0;
	logic         source_slip = 1'b0;
	logic         tx_transfer_done = 1'b0;
	logic         tx_buffer_copy_disable = 1'b0;
	logic [7:0]   status_flags;
	logic         converter_summary_flag;
	logic         int_n;
	logic [7:0]   irq_cnt;
	int           err_total = 0;
	int           compares = 0;
	sdi_interrupt_logic sdi_interrupt_logic_inst (.*);
	sdi_host sdi_host_inst (.*);
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		reg_req = '{write: w, addr: a, wdata: d};
		reg_valid = 1'b1;
		cyc(1);
		reg_valid = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(reg_rdata, exp);
	endtask
	task automatic trig(input logic [7:0] k, d, input logic [3:0] a, b, input logic [7:0] e);
		acc(1'b1, 8'h0B, k);
		acc(1'b1, 8'h0C, d);
		{rate_in_faster, estimator_ready, source_slip, tx_transfer_done} = a;
		cyc(5);
		acc(1'b0, 8'h0A, 8'h00);
		{rate_in_faster, estimator_ready, source_slip, tx_transfer_done} = b;
		cyc(4);
		chk(status_flags, e);
	endtask
	task automatic t_reset();
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h00);
		chk({7'h00, int_n}, 8'h01);
		$display("t_reset done");
	endtask
	task automatic t_regs();
		acc(1'b1, 8'h0B, 8'hFF);
		rd(8'h0B, 8'h33);
		acc(1'b1, 8'h0C, 8'hA5);
		rd(8'h0C, 8'hA5);
		rd(8'h55, 8'h00);
		$display("t_regs done");
	endtask
	task automatic t_events();
		trig(8'h20, 8'h00, 4'h0, 4'h8, 8'h20);
		rd(8'h02, 8'h02);
		chk({7'h00, int_n}, 8'h00);
		chk({7'h00, converter_summary_flag}, 8'h01);
		rd(8'h0A, 8'h20);
		rd(8'h0A, 8'h00);
		trig(8'h10, 8'h10, 4'h4, 4'h0, 8'h10);
		trig(8'h20, 8'h80, 4'h8, 4'h8, 8'h20);
		trig(8'h02, 8'h04, 4'h2, 4'h0, 8'h02);
		trig(8'h02, 8'h00, 4'h2, 4'h0, 8'h00);
		trig(8'h02, 8'h0C, 4'h0, 4'h2, 8'h00);
		trig(8'h01, 8'h02, 4'h0, 4'h1, 8'h01);
		trig(8'h01, 8'h01, 4'h1, 4'h0, 8'h01);
		trig(8'h00, 8'h00, 4'h0, 4'h4, 8'h00);
		tx_buffer_copy_disable = 1'b1;
		trig(8'h01, 8'h00, 4'h0, 4'h1, 8'h00);
		tx_buffer_copy_disable = 1'b0;
		trig(8'h01, 8'h00, 4'h0, 4'h1, 8'h01);
		trig(8'h20, 8'h40, 4'h8, 4'h0, 8'h20);
		trig(8'h10, 8'h20, 4'h4, 4'h4, 8'h10);
		trig(8'h02, 8'h08, 4'h2, 4'h2, 8'h02);
		chk({7'h00, irq_cnt != 8'h00}, 8'h01);
		$display("t_events done");
	endtask
	task automatic t_midreset();
		trig(8'h20, 8'h00, 4'h0, 4'h8, 8'h20);
		srst = 1'b1;
		cyc(3);
		srst = 1'b0;
		chk(status_flags, 8'h00);
		chk({7'h00, int_n}, 8'h01);
		rd(8'h0B, 8'h00);
		rd(8'h0C, 8'h00);
		cyc(4);
		chk(status_flags, 8'h00);
		$display("t_midreset done");
	endtask
	initial
	begin
		cyc(3);
		srst = 1'b0;
		t_reset();
		t_regs();
		t_events();
		t_midreset();
		stop_test();
	end
	initial
	begin
		#200us;
		err_total++;
		stop_test();
	end
endmodule
